// ### hw/sac_claimer.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Address search starts at the node type's default address.
// - Never claim an address in the static-node range.
// - On a lost or taken candidate, decrement and try again.
// - Dynamic node yields to static nodes and stronger identities; static keeps.
// - Keep watching claims; when displaced, rerun the claim procedure.
// - Identities compare as 64-bit values, smaller wins, capable flag on top.
// - Serial in bits 0..20, maker code in bits 21..31.
// - Byte 4 holds node instance (bits 0-2) and function instance (bits 3-7).
// - Identity bit 63 is one when dynamic, zero when fixed.
// - Maker-filtered request answered only when the maker code matches.
// - Request byte 0 bits 0-2 low maker bits, byte 1 high eight.
// - Maker-filtered request acknowledged with claim sent to global group.
// - Identity claim sent on request; dynamic node honours stronger claims.
// - Group requests answered with the claim when that group is asked.
// - Multi-packet transfer lives outside this block.
// - Every frame here fits one CAN frame with its own group number.
// - Address request: EAh high byte, source 254, payload 0, 238, 0; the source is not checked here, any source is answered.
// - Claim frame uses group EE00h, priority 6, identity as payload.
// - Static nodes answer address requests too.
module sac_claimer #(
  parameter logic [7:0] DEFAULT_ADDR = sac_pkg::DEF_ADDR,
  parameter logic [7:0] LOWEST_ADDR = sac_pkg::DEF_LOW,
  parameter int WAIT_CYCLES = 4000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic dynamic_mode,
  input wire logic [7:0] static_addr,
  input wire logic [20:0] serial_number,
  input wire logic [10:0] maker_code,
  input wire logic [2:0] node_instance,
  input wire logic [4:0] function_instance,
  input wire logic [22:0] compat_field,
  input wire logic start,
  input wire logic rx_valid,
  input wire logic [17:0] rx_group,
  input wire logic [7:0] rx_source_address,
  input wire logic [3:0] rx_len,
  input wire logic [63:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [17:0] tx_group,
  output logic [2:0] tx_priority,
  output logic [7:0] tx_source_address,
  output logic [3:0] tx_len,
  output logic [63:0] tx_data,
  output logic [7:0] source_address,
  output logic claimed,
  output logic failed
);
  // ----------------------------------------
  // Identity layout
  // ----------------------------------------
  logic [63:0] identity;
  assign identity = {dynamic_mode, 3'h0, compat_field[19:16], compat_field[15:9], 1'b0,
                     compat_field[7:0], function_instance, node_instance,
                     maker_code, serial_number};

  // byte-wise compare from byte 7 down
  function automatic logic other_wins(input logic [63:0] a, input logic [63:0] mine);
    logic res;
    logic done;
    res = 1'b0;
    done = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!done && a[i*8 +: 8] != mine[i*8 +: 8]) begin
        res = a[i*8 +: 8] < mine[i*8 +: 8];
        done = 1'b1;
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;
  logic [7:0] cand;
  logic [15:0] wait_cnt;
  logic reply_pend;
  logic reply_global;
  logic [7:0] my_addr;
  wire is_claim = rx_valid && rx_group == sac_pkg::GRP_ADDR_CLAIMED;
  wire claim_mine = is_claim && rx_source_address == my_addr;
  wire other_stronger = other_wins(rx_data, identity);
  wire is_addr_req = rx_valid && rx_group[17:8] == {2'b00, sac_pkg::REQ_HIGH} && rx_len == sac_pkg::REQ_LEN
                     && rx_data[15:8] == sac_pkg::REQ_BYTE1 && rx_data[7:0] == 8'h00 && rx_data[23:16] == 8'h00;
  wire req_for_me = is_addr_req && (rx_group[7:0] == my_addr || rx_group[7:0] == sac_pkg::GLOBAL_ADDR);
  wire maker_req = rx_valid && rx_group == sac_pkg::GRP_MAKER_REQ;
  wire maker_hit = maker_req && {rx_data[15:8], rx_data[2:0]} == maker_code;
  // answer a request; group request for the claim group; static too
  wire want_reply = (req_for_me || maker_hit) && (claimed || !dynamic_mode);
  assign my_addr = dynamic_mode ? cand : static_addr;
  wire [7:0] dec_cand = cand - 8'h01;
  wire can_dec = cand > LOWEST_ADDR;
  wire lost_now = claim_mine && dynamic_mode && other_stronger;

  // ----------------------------------------
  // Claim sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      sac_pkg::SAC_IDLE: begin
        if (start || !dynamic_mode && start) begin
          next_state = sac_pkg::SAC_SEND;
        end
      end
      sac_pkg::SAC_SEND: begin
        if (tx_valid && tx_ready) begin
          next_state = dynamic_mode ? sac_pkg::SAC_WAIT : sac_pkg::SAC_HOLD;
        end
      end
      sac_pkg::SAC_WAIT: begin
        if (lost_now) begin
          next_state = can_dec ? sac_pkg::SAC_SEND : sac_pkg::SAC_LOST;
        end else if (wait_cnt == 16'(WAIT_CYCLES)) begin
          next_state = sac_pkg::SAC_HOLD;
        end
      end
      sac_pkg::SAC_HOLD: begin
        // displaced node reclaims; yield to stronger
        if (lost_now) begin
          next_state = can_dec ? sac_pkg::SAC_SEND : sac_pkg::SAC_LOST;
        end
      end
      sac_pkg::SAC_LOST: next_state = sac_pkg::SAC_LOST;
      default: next_state = sac_pkg::SAC_IDLE;
    endcase
  end

  wire send_claim = state == sac_pkg::SAC_SEND || reply_pend;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= sac_pkg::SAC_IDLE;
      cand <= DEFAULT_ADDR;
      wait_cnt <= 16'h0000;
      reply_pend <= 1'b0;
      reply_global <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (lost_now && can_dec) begin
        cand <= dec_cand;
      end
      wait_cnt <= (state == sac_pkg::SAC_WAIT && !lost_now) ? wait_cnt + 16'h0001 : 16'h0000;
      if (want_reply) begin
        reply_pend <= 1'b1;
        // Request strobe is gone by send time, so remember which group to answer with
        reply_global <= maker_hit;
      end else if (tx_valid && tx_ready) begin
        reply_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      tx_group <= 18'h00000;
      tx_priority <= 3'h0;
      tx_source_address <= 8'h00;
      tx_len <= 4'h0;
      tx_data <= 64'h0000000000000000;
      source_address <= sac_pkg::NULL_ADDR;
      claimed <= 1'b0;
      failed <= 1'b0;
    end else if (ce) begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end else if (send_claim && !tx_valid) begin
        tx_valid <= 1'b1;
        // claim frame; maker ack goes global; single frame
        // multi-packet text is left to the transport
        tx_group <= (reply_pend && reply_global) ? sac_pkg::GRP_CLAIMED_GLOBAL : sac_pkg::GRP_ADDR_CLAIMED;
        tx_priority <= sac_pkg::CLAIM_PRIO;
        tx_source_address <= (state == sac_pkg::SAC_LOST) ? sac_pkg::NULL_ADDR : my_addr;
        tx_len <= sac_pkg::CLAIM_LEN;
        tx_data <= identity;
      end
      claimed <= next_state == sac_pkg::SAC_HOLD;
      failed <= next_state == sac_pkg::SAC_LOST;
      source_address <= (next_state == sac_pkg::SAC_HOLD) ? my_addr : sac_pkg::NULL_ADDR;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_prio;
    @(posedge clk) disable iff (!rstn) tx_valid |-> tx_priority == sac_pkg::CLAIM_PRIO;
  endproperty
  a_prio: assert property (p_prio) else $error("claim priority wrong");
  property p_payload;
    @(posedge clk) disable iff (!rstn) tx_valid |-> tx_data == identity && tx_len == sac_pkg::CLAIM_LEN;
  endproperty
  a_payload: assert property (p_payload) else $error("claim payload wrong");
  property p_dec;
    @(posedge clk) disable iff (!rstn) ce && lost_now && can_dec |=> cand == $past(cand) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");
  property p_floor;
    @(posedge clk) disable iff (!rstn) dynamic_mode |-> cand >= LOWEST_ADDR;
  endproperty
  a_floor: assert property (p_floor) else $error("static range entered");
  property p_yield;
    @(posedge clk) disable iff (!rstn) ce && claimed && lost_now |=> !claimed;
  endproperty
  a_yield: assert property (p_yield) else $error("did not yield");
  property p_cap;
    @(posedge clk) disable iff (!rstn) tx_valid |-> tx_data[63] == dynamic_mode && tx_data[62:60] == 3'h0;
  endproperty
  a_cap: assert property (p_cap) else $error("capable bit wrong");
  property p_maker;
    @(posedge clk) disable iff (!rstn) tx_data[31:21] == maker_code || !tx_valid;
  endproperty
  a_maker: assert property (p_maker) else $error("maker field wrong");
  property p_reply;
    @(posedge clk) disable iff (!rstn) ce && want_reply && !tx_valid ##1 ce |-> ##[0:3] tx_valid;
  endproperty
  a_reply: assert property (p_reply) else $error("request unanswered");
  property p_maker_silent;
    @(posedge clk) disable iff (!rstn) ce && maker_req && !maker_hit && !reply_pend |=> !reply_pend;
  endproperty
  a_maker_silent: assert property (p_maker_silent) else $error("foreign maker answered");
  property p_unclaimed_silent;
    @(posedge clk) disable iff (!rstn) ce && dynamic_mode && !claimed && !reply_pend |=> !reply_pend;
  endproperty
  a_unclaimed_silent: assert property (p_unclaimed_silent) else $error("unclaimed node replied");
  property p_maker_ack;
    @(posedge clk) disable iff (!rstn) ce && maker_hit && (claimed || !dynamic_mode) |=> reply_pend && reply_global;
  endproperty
  a_maker_ack: assert property (p_maker_ack) else $error("maker request not acknowledged");
  property p_req_static;
    @(posedge clk) disable iff (!rstn) ce && req_for_me && !dynamic_mode |=> reply_pend;
  endproperty
  a_req_static: assert property (p_req_static) else $error("static node ignored request");
  property p_ready_drop;
    @(posedge clk) disable iff (!rstn) ce && tx_valid && tx_ready |=> !tx_valid;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("frame sent twice");
  property p_hold_frame;
    @(posedge clk) disable iff (!rstn) ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_group)
      && $stable(tx_source_address) && $stable(tx_data);
  endproperty
  a_hold_frame: assert property (p_hold_frame) else $error("frame changed while waiting");
  property p_reclaim;
    @(posedge clk) disable iff (!rstn) ce && lost_now && can_dec && state == sac_pkg::SAC_HOLD
      |=> state == sac_pkg::SAC_SEND;
  endproperty
  a_reclaim: assert property (p_reclaim) else $error("no reclaim after displacement");
  property p_lost_floor;
    @(posedge clk) disable iff (!rstn) ce && lost_now && !can_dec
      && (state == sac_pkg::SAC_HOLD || state == sac_pkg::SAC_WAIT) |=> failed;
  endproperty
  a_lost_floor: assert property (p_lost_floor) else $error("went below lowest address");
  property p_static_keeps;
    @(posedge clk) disable iff (!rstn) ce && !dynamic_mode && claimed && claim_mine |=> claimed;
  endproperty
  a_static_keeps: assert property (p_static_keeps) else $error("static node gave up address");
  property p_weak_ignored;
    @(posedge clk) disable iff (!rstn) ce && dynamic_mode && claimed && claim_mine && !other_stronger |=> claimed;
  endproperty
  a_weak_ignored: assert property (p_weak_ignored) else $error("yielded to weaker identity");
  property p_wait_bound;
    @(posedge clk) disable iff (!rstn) state == sac_pkg::SAC_WAIT |-> wait_cnt <= 16'(WAIT_CYCLES);
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("wait counter overran");
  property p_start_send;
    @(posedge clk) disable iff (!rstn) ce && start && state == sac_pkg::SAC_IDLE |=> state == sac_pkg::SAC_SEND;
  endproperty
  a_start_send: assert property (p_start_send) else $error("start ignored");
  property p_fail_sticky;
    @(posedge clk) disable iff (!rstn) failed |=> failed;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag dropped");
  property p_excl;
    @(posedge clk) disable iff (!rstn) !(claimed && failed);
  endproperty
  a_excl: assert property (p_excl) else $error("claimed and failed together");
  property p_sa_claimed;
    @(posedge clk) disable iff (!rstn) claimed |-> source_address == my_addr;
  endproperty
  a_sa_claimed: assert property (p_sa_claimed) else $error("claimed address wrong");
  property p_unclaimed_null;
    @(posedge clk) disable iff (!rstn) !claimed |-> source_address == sac_pkg::NULL_ADDR;
  endproperty
  a_unclaimed_null: assert property (p_unclaimed_null) else $error("address shown while unclaimed");
  property p_grp;
    @(posedge clk) disable iff (!rstn) tx_valid |-> tx_group == sac_pkg::GRP_ADDR_CLAIMED
      || tx_group == sac_pkg::GRP_CLAIMED_GLOBAL;
  endproperty
  a_grp: assert property (p_grp) else $error("claim group wrong");
  property p_src_static;
    @(posedge clk) disable iff (!rstn) tx_valid && !dynamic_mode |-> tx_source_address == static_addr;
  endproperty
  a_src_static: assert property (p_src_static) else $error("static source wrong");
  property p_cmp_top;
    @(posedge clk) disable iff (!rstn) rx_data[63:56] < identity[63:56] |-> other_stronger;
  endproperty
  a_cmp_top: assert property (p_cmp_top) else $error("top byte compare wrong");
  property p_cmp_low;
    @(posedge clk) disable iff (!rstn) rx_data[63:8] == identity[63:8] && rx_data[7:0] > identity[7:0]
      |-> !other_stronger;
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("low byte compare wrong");
  property p_reserved;
    @(posedge clk) disable iff (!rstn) tx_valid |-> tx_data[48] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_inst;
    @(posedge clk) disable iff (!rstn) tx_valid |-> tx_data[39:32] == {function_instance, node_instance};
  endproperty
  a_inst: assert property (p_inst) else $error("instance byte wrong");
  property p_serial;
    @(posedge clk) disable iff (!rstn) tx_valid |-> tx_data[20:0] == serial_number;
  endproperty
  a_serial: assert property (p_serial) else $error("serial field wrong");
  property p_ce_freeze;
    @(posedge clk) disable iff (!rstn) !ce |=> $stable(state) && $stable(cand) && $stable(tx_valid);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");
  property p_lost_fail;
    @(posedge clk) disable iff (!rstn) state == sac_pkg::SAC_LOST |-> failed;
  endproperty
  a_lost_fail: assert property (p_lost_fail) else $error("lost without failure flag");
  c_claim: cover property (@(posedge clk) disable iff (!rstn) !claimed ##1 claimed);
  c_lost: cover property (@(posedge clk) disable iff (!rstn) lost_now);
  c_maker: cover property (@(posedge clk) disable iff (!rstn) maker_hit);
  c_static: cover property (@(posedge clk) disable iff (!rstn) !dynamic_mode && claimed);
  c_global: cover property (@(posedge clk) disable iff (!rstn) tx_valid && tx_group == sac_pkg::GRP_CLAIMED_GLOBAL);
endmodule

// ### hw/sac_pkg.sv
package sac_pkg;
  // ----------------------------------------
  // Group numbers and frame constants
  // ----------------------------------------
  localparam logic [17:0] GRP_ADDR_CLAIMED = 18'h0EE00;
  localparam logic [17:0] GRP_CLAIMED_GLOBAL = 18'h0EEFF;
  localparam logic [17:0] GRP_MAKER_REQ = 18'h1FED6;
  localparam logic [7:0] REQ_HIGH = 8'hEA;
  localparam logic [7:0] REQ_BYTE1 = 8'hEE;
  localparam logic [7:0] NULL_ADDR = 8'hFE;
  localparam logic [7:0] GLOBAL_ADDR = 8'hFF;
  localparam logic [2:0] CLAIM_PRIO = 3'h6;
  localparam logic [3:0] REQ_LEN = 4'h3;
  localparam logic [3:0] CLAIM_LEN = 4'h8;
  // ----------------------------------------
  // Identity field positions
  // ----------------------------------------
  localparam int SERIAL_LSB = 0;
  localparam int MAKER_LSB = 21;
  localparam int NODE_INST_LSB = 32;
  localparam int FUNC_INST_LSB = 35;
  localparam int COMPAT_LSB = 40;
  localparam int CAPABLE_BIT = 63;
  localparam logic [7:0] DEF_ADDR = 8'h80;
  localparam logic [7:0] DEF_LOW = 8'h80;
  typedef enum {SAC_IDLE, SAC_SEND, SAC_WAIT, SAC_HOLD, SAC_LOST} sac_state_t;
endpackage

// ### verif/sac_peer.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-side node and its frame transport
// ----------------------------------------
module sac_peer (
  input wire logic clk,
  input wire logic [3:0] stall,
  input wire logic tx_valid,
  input wire logic [17:0] tx_group,
  input wire logic [2:0] tx_priority,
  input wire logic [7:0] tx_source_address,
  input wire logic [3:0] tx_len,
  input wire logic [63:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [17:0] rx_group,
  output logic [7:0] rx_source_address,
  output logic [3:0] rx_len,
  output logic [63:0] rx_data
);
  logic [3:0] waited;
  logic [96:0] last_frame;
  int frames;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    {rx_group, rx_source_address, rx_len, rx_data} = '0;
    waited = 4'h0;
    frames = 0;
  end
  // Slow transport: ready only after the chosen stall
  always @(negedge clk) begin
    tx_ready <= tx_valid && !tx_ready && waited >= stall;
    waited <= (tx_valid && !tx_ready) ? waited + 4'h1 : 4'h0;
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      last_frame <= {tx_group, tx_priority, tx_source_address, tx_len, tx_data};
      frames <= frames + 1;
    end
  end
  // one frame each
  // Released lines show the inverse so a stale value is never read as fresh
  task automatic send(input logic [17:0] g, input logic [7:0] s, input logic [3:0] n, input logic [63:0] d);
    @(negedge clk);
    {rx_valid, rx_group, rx_source_address, rx_len, rx_data} <= {1'b1, g, s, n, d};
    @(negedge clk);
    {rx_valid, rx_group, rx_source_address, rx_len, rx_data} <= {1'b0, ~g, ~s, ~n, ~d};
  endtask
endmodule

// ### verif/test_can_source_address_claimer.sv
`timescale 1ns/100ps
module test_can_source_address_claimer;
  localparam logic [10:0] maker = 11'h5A3;
  localparam logic [20:0] serial = 21'h1ABCDE;
  logic clk = 0, rstn = 0, start = 0, dyn = 1;
  logic [7:0] st = 8'h35;
  logic [2:0] node = 3'h5;
  logic [4:0] func = 5'h0A;
  logic [22:0] compat = 23'h7FFFFF;
  logic [3:0] stall = 4'h3;
  logic tv, tr, rv, claimed, failed;
  logic [17:0] tg, rg;
  logic [2:0] tp;
  logic [7:0] ts, rs, sa;
  logic [3:0] tl, rl;
  logic [63:0] td, rd;
  int num_errors = 0, num_checks = 0;
  sac_claimer #(.DEFAULT_ADDR(8'h82), .LOWEST_ADDR(8'h80), .WAIT_CYCLES(20)) sac_claimer_i (.clk(clk), .rstn(rstn),
    .ce(1'b1), .dynamic_mode(dyn), .static_addr(st), .serial_number(serial), .maker_code(maker),
    .node_instance(node), .function_instance(func), .compat_field(compat), .start(start), .rx_valid(rv),
    .rx_group(rg), .rx_source_address(rs), .rx_len(rl), .rx_data(rd), .tx_ready(tr), .tx_valid(tv),
    .tx_group(tg), .tx_priority(tp), .tx_source_address(ts), .tx_len(tl), .tx_data(td),
    .source_address(sa), .claimed(claimed), .failed(failed));
  sac_peer sac_peer_i (.clk(clk), .stall(stall), .tx_valid(tv), .tx_group(tg), .tx_priority(tp),
    .tx_source_address(ts), .tx_len(tl), .tx_data(td), .tx_ready(tr), .rx_valid(rv), .rx_group(rg),
    .rx_source_address(rs), .rx_len(rl), .rx_data(rd));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [63:0] exp_id();
    logic [63:0] v;
    v = {dyn, compat, func, node, maker, serial};
    v[48] = 1'b0;
    v[62:60] = 3'h0;
    return v;
  endfunction
  task automatic check(input logic [96:0] seen, input logic [96:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic expect_tx(input logic [17:0] g, input logic [7:0] s);
    int n;
    n = sac_peer_i.frames;
    for (int i = 0; i < 40 && sac_peer_i.frames == n; i++) @(negedge clk);
    check(sac_peer_i.frames - n, 1);
    check(sac_peer_i.last_frame, {g, 3'h6, s, 4'h8, exp_id()});
  endtask
  task automatic wait_claim(input logic [7:0] a);
    for (int i = 0; i < 60 && claimed !== 1'b1; i++) @(negedge clk);
    check({claimed, sa}, {1'b1, a});
  endtask
  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    check({sa, claimed, failed, tv}, {8'hFE, 3'h0});
  endtask
  task automatic do_start();
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_claim();
    do_start();
    expect_tx(18'h0EE00, 8'h82);
    wait_claim(8'h82);
  endtask
  task automatic t_request();
    sac_peer_i.send(18'h0EA82, 8'hFE, 4'h3, 64'h0EE00);
    expect_tx(18'h0EE00, 8'h82);
    sac_peer_i.send(18'h0EAFF, 8'h21, 4'h3, 64'h0EE00);
    expect_tx(18'h0EE00, 8'h82);
  endtask
  task automatic t_maker();
    sac_peer_i.send(18'h1FED6, 8'h21, 4'h3, {48'h0, maker[10:3], 5'h0, maker[2:0]});
    expect_tx(18'h0EEFF, 8'h82);
    sac_peer_i.send(18'h1FED6, 8'h21, 4'h3, {48'h0, maker[10:3], 5'h0, ~maker[2:0]});
    repeat (30) @(negedge clk);
    check(sac_peer_i.frames, 4);
  endtask
  task automatic t_lose();
    stall = 4'h0;
    sac_peer_i.send(18'h0EE00, 8'h82, 4'h8, exp_id() - 64'h1);
    expect_tx(18'h0EE00, 8'h81);
    wait_claim(8'h81);
    sac_peer_i.send(18'h0EE00, 8'h81, 4'h8, 64'h0);
    expect_tx(18'h0EE00, 8'h80);
    wait_claim(8'h80);
    sac_peer_i.send(18'h0EE00, 8'h80, 4'h8, 64'h0);
    repeat (30) @(negedge clk);
    check({failed, claimed, sa}, {2'b10, 8'hFE});
  endtask
  task automatic t_static();
    dyn = 1'b0;
    node = 3'h2;
    func = 5'h11;
    compat = 23'h0;
    do_reset();
    do_start();
    expect_tx(18'h0EE00, 8'h35);
    wait_claim(8'h35);
    sac_peer_i.send(18'h0EE00, 8'h35, 4'h8, 64'h0);
    repeat (30) @(negedge clk);
    check({failed, claimed, sa}, {2'b01, 8'h35});
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    do_reset();
    t_claim();
    t_request();
    t_maker();
    t_lose();
    t_static();
    complete_run();
  end
  // Run needs under a thousand cycles; four thousand is ample
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
